// File: rtl/iocs_clk_switch.sv
// internal oscillator clock switch: sequences a glitch-free change of the
// system clock between the low, mid and high frequency internal oscillators
// assumes freq_sel_in comes from logic on mclk_in, oscillators are async
//
// Functional notes
// - powered-down target oscillator gets start-up delay first
// - then wait for falling edge of old clock
// - hold system clock low until new rising edge
// - update oscillator status, then switch is done
// - status shows the one internal oscillator in use, updated at switch end
// - same source: no delay, select directly
`include "iocs_defs.svh"

module iocs_clk_switch (
    input  wire logic       mclk_in,         // core clock, 40 MHz
    input  wire logic       rstn_in,         // async reset, active low
    input  wire logic [3:0] freq_sel_in,     // internal_freq_select field
    input  wire logic [2:0] osc_clk_in,      // oscillators: 0 low, 1 mid, 2 high
    output logic            sys_clk_out,     // switched system clock
    output logic [2:0]      osc_en_out,      // oscillator power enables
    output logic [2:0]      osc_status_out,  // osc_status_reg active bits
    output logic [3:0]      active_sel_out,  // select now in effect
    output logic            switch_busy_out  // switch in progress
);

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic iocs_pkg::iocs_src_t src_of(input logic [3:0] sel);
        if (sel >= `IOCS_HF_MIN_SEL) begin
            src_of = `IOCS_SRC_HF;
        end else if (sel >= `IOCS_MF_MIN_SEL) begin
            src_of = `IOCS_SRC_MF;
        end else begin
            src_of = `IOCS_SRC_LF;
        end
    endfunction

    function automatic logic [2:0] onehot(input iocs_pkg::iocs_src_t s);
        onehot    = 3'h0;
        onehot[s] = 1'b1;
    endfunction

    // ****************************************************************
    // oscillator synchronisers
    // ****************************************************************
    iocs_osc_if osc ();

    iocs_osc_sync u_sync (
        .mclk_in (mclk_in),
        .rstn_in (rstn_in),
        .osc_in  (osc_clk_in),
        .osc_if  (osc)
    );

    // ****************************************************************
    // switch sequencer
    // ****************************************************************
    iocs_pkg::iocs_state_e state_ff;
    iocs_pkg::iocs_state_e nxt_state;
    logic [3:0]            cur_ff;
    logic [3:0]            nxt_cur;
    logic [3:0]            tgt_ff;
    logic [3:0]            nxt_tgt;
    logic [7:0]            cnt_ff;
    logic [7:0]            nxt_cnt;
    logic [2:0]            en_ff;
    logic [2:0]            nxt_en;
    logic [2:0]            stat_ff;
    logic [2:0]            nxt_stat;
    logic                  sys_clk_ff;
    logic                  nxt_clk;
    iocs_pkg::iocs_src_t   cur_src;
    iocs_pkg::iocs_src_t   new_src;
    iocs_pkg::iocs_src_t   in_src;
    logic                  req;
    logic                  same_src;
    logic                  cur_lvl;

    // request decode against the select in effect
    assign cur_src  = src_of(cur_ff);
    assign new_src  = src_of(tgt_ff);
    assign in_src   = src_of(freq_sel_in);
    assign req      = (freq_sel_in != cur_ff);
    assign same_src = (in_src == cur_src);
    assign cur_lvl  = osc.lvl[cur_src];

    // next-state and datapath
    always_comb begin
        nxt_state = state_ff;
        nxt_cur   = cur_ff;
        nxt_tgt   = tgt_ff;
        nxt_cnt   = cnt_ff;
        nxt_en    = en_ff;
        nxt_stat  = stat_ff;
        nxt_clk   = sys_clk_ff;
        unique case (state_ff)
            iocs_pkg::st_idle: begin
                nxt_clk = cur_lvl;  // follow active source
                if (req) begin
                    nxt_tgt = freq_sel_in;
                    if (same_src) begin
                        nxt_cur = freq_sel_in;  // direct select
                    end else if (!en_ff[in_src]) begin
                        nxt_en    = en_ff | onehot(in_src);  // power up
                        nxt_cnt   = 8'(`IOCS_STARTUP_CYC);
                        nxt_state = iocs_pkg::st_start;
                    end else begin
                        nxt_state = iocs_pkg::st_wfall;
                    end
                end
            end
            iocs_pkg::st_start: begin
                nxt_clk = cur_lvl;
                if (cnt_ff == 8'h00) begin
                    nxt_state = iocs_pkg::st_wfall;  // delay over
                end else begin
                    nxt_cnt = cnt_ff - 8'h01;
                end
            end
            iocs_pkg::st_wfall: begin
                nxt_clk = cur_lvl;
                if (osc.fall[cur_src]) begin
                    nxt_clk   = 1'b0;  // old clock just fell
                    nxt_state = iocs_pkg::st_hold;
                end
            end
            iocs_pkg::st_hold: begin
                nxt_clk = 1'b0;  // held low
                if (osc.rise[new_src]) begin
                    nxt_clk   = 1'b1;  // full high phase of new clock
                    nxt_cur   = tgt_ff;
                    nxt_state = iocs_pkg::st_upd;
                end
            end
            iocs_pkg::st_upd: begin
                nxt_clk   = cur_lvl;
                nxt_stat  = onehot(cur_src);  // status after switch
                nxt_en    = onehot(cur_src);  // old oscillator may power down
                nxt_state = iocs_pkg::st_idle;
            end
            default: begin
                nxt_state = iocs_pkg::st_idle;
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_ff   <= iocs_pkg::st_idle;
            cur_ff     <= `IOCS_SEL_RST;
            tgt_ff     <= `IOCS_SEL_RST;
            cnt_ff     <= 8'h00;
            en_ff      <= `IOCS_EN_RST;
            stat_ff    <= `IOCS_STAT_RST;
            sys_clk_ff <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            cur_ff     <= nxt_cur;
            tgt_ff     <= nxt_tgt;
            cnt_ff     <= nxt_cnt;
            en_ff      <= nxt_en;
            stat_ff    <= nxt_stat;
            sys_clk_ff <= nxt_clk;
        end
    end

    // outputs
    assign sys_clk_out     = sys_clk_ff;
    assign osc_en_out      = en_ff;
    assign osc_status_out  = stat_ff;
    assign active_sel_out  = cur_ff;
    assign switch_busy_out = (state_ff != iocs_pkg::st_idle);

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);

    start_entry_a: assert property (
        (state_ff == iocs_pkg::st_idle && req && !same_src && !en_ff[in_src])
        |=> (state_ff == iocs_pkg::st_start) && (cnt_ff == 8'(`IOCS_STARTUP_CYC)))
        else $error("powered-down target did not start delay");

    start_hold_a: assert property (
        (state_ff == iocs_pkg::st_start && cnt_ff != 8'h00)
        |=> state_ff == iocs_pkg::st_start)
        else $error("start-up delay cut short");

    wait_fall_a: assert property (
        (state_ff == iocs_pkg::st_wfall && !osc.fall[cur_src])
        |=> state_ff == iocs_pkg::st_wfall && cur_ff == $past(cur_ff))
        else $error("left falling-edge wait without an edge");

    hold_low_a: assert property (
        (state_ff == iocs_pkg::st_hold) |-> !sys_clk_ff)
        else $error("system clock not held low");

    hold_exit_a: assert property (
        (state_ff == iocs_pkg::st_hold && osc.rise[new_src])
        |=> state_ff == iocs_pkg::st_upd && sys_clk_ff && cur_ff == $past(tgt_ff))
        else $error("new rising edge not taken");

    status_upd_a: assert property (
        (state_ff == iocs_pkg::st_upd)
        |=> state_ff == iocs_pkg::st_idle && stat_ff == onehot(cur_src))
        else $error("status not updated at switch end");

    status_match_a: assert property (
        (state_ff == iocs_pkg::st_idle) |-> stat_ff == onehot(cur_src))
        else $error("status does not match active source");

    same_src_a: assert property (
        (state_ff == iocs_pkg::st_idle && req && same_src)
        |=> state_ff == iocs_pkg::st_idle && cur_ff == $past(freq_sel_in))
        else $error("same-source change not direct");

    clk_follow_a: assert property (
        (state_ff == iocs_pkg::st_idle) |=> sys_clk_ff == $past(cur_lvl))
        else $error("system clock not following active source");

    start_seen_c: cover property (state_ff == iocs_pkg::st_start ##1 cnt_ff == 8'h00);
    direct_seen_c: cover property (state_ff == iocs_pkg::st_idle && req && same_src);
    switch_done_c: cover property (state_ff == iocs_pkg::st_hold ##1
                                   state_ff == iocs_pkg::st_upd);

endmodule

// File: rtl/iocs_defs.svh
// constants for the internal oscillator clock switch
// assumes the core clock mclk_in runs at 40 MHz
`ifndef IOCS_DEFS_SVH
`define IOCS_DEFS_SVH

// ****************************************************************
// timing
// ****************************************************************
`define IOCS_CLK_MHZ       40
`define IOCS_STARTUP_NS    2000
`define IOCS_STARTUP_CYC   ((`IOCS_STARTUP_NS * `IOCS_CLK_MHZ + 999) / 1000)

// ****************************************************************
// oscillator sources and select decode
// ****************************************************************
`define IOCS_SRC_LF        2'h0
`define IOCS_SRC_MF        2'h1
`define IOCS_SRC_HF        2'h2
`define IOCS_MF_MIN_SEL    4'h1
`define IOCS_HF_MIN_SEL    4'h7

// ****************************************************************
// reset values
// ****************************************************************
`define IOCS_SEL_RST       4'h0
`define IOCS_EN_RST        3'h1
`define IOCS_STAT_RST      3'h1

`endif

// File: rtl/iocs_osc_if.sv
// synchronised oscillator levels and edges, one bit per source
// assumes bit 0 low, bit 1 mid, bit 2 high frequency oscillator
interface iocs_osc_if;
    logic [2:0] lvl;
    logic [2:0] rise;
    logic [2:0] fall;

    modport src (output lvl, output rise, output fall);
    modport snk (input lvl, input rise, input fall);
endinterface

// File: rtl/iocs_osc_sync.sv
// two-flop synchronisers and edge detect for the three oscillators
// assumes oscillator inputs are asynchronous to mclk_in
module iocs_osc_sync (
    input  wire logic       mclk_in,   // core clock
    input  wire logic       rstn_in,   // async reset, active low
    input  wire logic [2:0] osc_in,    // raw oscillator levels
    iocs_osc_if.src         osc_if     // synced levels and edges
);

    genvar gi;

    // ****************************************************************
    // per-oscillator synchroniser
    // ****************************************************************
    generate
        for (gi = 0; gi < 3; gi++) begin : g_osc
            logic meta_ff;
            logic sync_ff;
            logic dly_ff;
            logic nxt_meta;
            logic nxt_sync;
            logic nxt_dly;

            // next values: meta feeds only sync
            always_comb begin
                nxt_meta = osc_in[gi];
                nxt_sync = meta_ff;
                nxt_dly  = sync_ff;
            end

            // register stage
            always_ff @(posedge mclk_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    meta_ff <= 1'b0;
                    sync_ff <= 1'b0;
                    dly_ff  <= 1'b0;
                end else begin
                    meta_ff <= nxt_meta;
                    sync_ff <= nxt_sync;
                    dly_ff  <= nxt_dly;
                end
            end

            // level and edges from the second and third flops
            assign osc_if.lvl[gi]  = sync_ff;
            assign osc_if.rise[gi] = sync_ff & ~dly_ff;
            assign osc_if.fall[gi] = ~sync_ff & dly_ff;
        end
    endgenerate

endmodule

// File: rtl/iocs_pkg.sv
// types for the internal oscillator clock switch
// assumes iocs_defs.svh holds the numeric constants
package iocs_pkg;

    // ****************************************************************
    // switch sequencer states, gray on the path through st_start, not on st_upd to st_idle
    // ****************************************************************
    typedef enum logic [2:0] {
        st_idle  = 3'h0,
        st_start = 3'h1,
        st_wfall = 3'h3,
        st_hold  = 3'h2,
        st_upd   = 3'h6
    } iocs_state_e;

    typedef logic [1:0] iocs_src_t;

endpackage

// File: verification/iocs_clk_switch_test.sv
// ****************************************************************
// self-checking bench for the internal oscillator clock switch
// ****************************************************************
// assumes iocs_osc_model stands in for the three oscillators
module iocs_clk_switch_test;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int MIN_PH = 3;  // shortest source half period less sync jitter

    logic       mclk     = 1'b0;
    logic       rstn     = 1'b0;
    logic [3:0] freq_sel = 4'h0;
    logic [2:0] osc_clk;
    logic       sys_clk;
    logic [2:0] osc_en;
    logic [2:0] osc_stat;
    logic [3:0] act_sel;
    logic       busy;
    int         errors      = 0;
    int         checks_done = 0;
    int         cyc         = 0;
    int         ph          = 0;
    logic       armed       = 1'b0;
    logic       prev_clk    = 1'b0;
    logic [3:0] prev_sel    = 4'h0;

    iocs_clk_switch dut (
        .mclk_in         (mclk),
        .rstn_in         (rstn),
        .freq_sel_in     (freq_sel),
        .osc_clk_in      (osc_clk),
        .sys_clk_out     (sys_clk),
        .osc_en_out      (osc_en),
        .osc_status_out  (osc_stat),
        .active_sel_out  (act_sel),
        .switch_busy_out (busy)
    );

    iocs_osc_model osc (
        .en_in   (osc_en),
        .osc_out (osc_clk)
    );

    // 40 MHz core clock
    always #12.5 mclk = ~mclk;

    // hang guard
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            print_verdict();
        end
    end

    task automatic check_val(input string name, input logic [3:0] exp, input logic [3:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    // phase lengths of the system clock, and the hand-over edge
    always @(negedge mclk) begin
        if (rstn && armed && sys_clk !== prev_clk) begin
            check_val("sys_clk_phase_ok", 4'h1, {3'h0, ph >= MIN_PH});
        end
        if (rstn && busy === 1'b1 && act_sel !== prev_sel) begin
            check_val("handover_rise", 4'h1, {3'h0, sys_clk});
            check_val("held_low_before", 4'h0, {3'h0, prev_clk});
        end
        armed    <= rstn && (armed || sys_clk !== prev_clk);
        ph       <= (sys_clk !== prev_clk) ? 1 : ph + 1;
        prev_clk <= sys_clk;
        prev_sel <= act_sel;
    end

    // request a select, wait for the switch, judge the result
    task automatic do_switch(input logic [3:0] sel, input logic [2:0] st, input int min_busy);
        int n;
        int w;
        n = 0;
        w = 0;
        @(posedge mclk);
        freq_sel <= sel;
        while (w < 400) begin
            @(posedge mclk);
            #1;
            w++;
            if (busy === 1'b1) begin
                n++;
            end else if (n > 0 || (min_busy == 0 && w > 3)) begin
                break;
            end
        end
        check_val("busy_span_ok", 4'h1, {3'h0, (min_busy == 0) ? n == 0 : n >= min_busy});
        check_val("busy_done", 4'h0, {3'h0, busy});
        check_val("active_sel", sel, act_sel);
        check_val("osc_status", {1'b0, st}, {1'b0, osc_stat});
        check_val("osc_enable", {1'b0, st}, {1'b0, osc_en});
    endtask

    task automatic test_reset();
        check_val("rst_status", 4'h1, {1'b0, osc_stat});
        check_val("rst_sel", 4'h0, act_sel);
        check_val("rst_busy", 4'h0, {3'h0, busy});
        $display("test_reset done");
    endtask

    task automatic test_low_to_high();
        do_switch(4'h7, 3'h4, 81);
        $display("test_low_to_high done");
    endtask

    task automatic test_same_source();
        do_switch(4'hF, 3'h4, 0);
        do_switch(4'h2, 3'h2, 81);
        do_switch(4'h6, 3'h2, 0);
        $display("test_same_source done");
    endtask

    task automatic test_mid_to_low();
        do_switch(4'h0, 3'h1, 81);
        do_switch(4'h1, 3'h2, 81);
        $display("test_mid_to_low done");
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (20) @(posedge mclk);
        rstn <= 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        test_reset();
        test_low_to_high();
        test_same_source();
        test_mid_to_low();
        print_verdict();
    end
endmodule

// File: verification/iocs_osc_model.sv
// ****************************************************************
// oscillator model for the clock switch bench
// ****************************************************************
// holds the low, mid and high frequency internal oscillators
// assumes enables come from the switch; a stopped oscillator stands low
module iocs_osc_model #(
    parameter int START_NS = 503  // settle time, keeps edges off the core clock edge
) (
    input  wire logic [2:0] en_in,   // power enables, 0 low 1 mid 2 high
    output logic      [2:0] osc_out  // oscillator clocks
);
    timeunit 1ns;
    timeprecision 1ps;

    localparam int HALF_NS [3] = '{200, 150, 100};

    for (genvar i = 0; i < 3; i++) begin : g_osc
        // stopped while unpowered, slow to start after power-up
        initial begin
            osc_out[i] = 1'b0;
            forever begin
                if (en_in[i] !== 1'b1) begin
                    osc_out[i] = 1'b0;
                    @(posedge en_in[i]);
                    #(START_NS);
                end else begin
                    #(HALF_NS[i]);
                    osc_out[i] = en_in[i] & ~osc_out[i];
                end
            end
        end
    end
endmodule
